// ===== rtl/code_flasher.sv
`timescale 1ns/1ns
`include "lamp_defines.svh"
// serialises an 8-bit code, msb first, as long/short pulses, repeating with a pause
module code_flasher #(
  parameter int unsigned LONG_CYC = `MS_CYCLES(`LONG_PULSE_MS),
  parameter int unsigned SHORT_CYC = `MS_CYCLES(`SHORT_PULSE_MS),
  parameter int unsigned GAP_CYC = `MS_CYCLES(`BIT_GAP_MS),
  parameter int unsigned PAUSE_CYC = `MS_CYCLES(`CODE_PAUSE_MS)
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic run,
  input wire logic [7:0] code,
  output logic lamp
);
  logic [31:0] cnt_r;
  logic [2:0] bit_r;
  logic on_r;
  logic pause_r;
  logic lamp_r;
  logic [31:0] lit_len_r;
  logic lit_bit_r;
  logic [3:0] pulse_cnt_r;
  wire cur_bit = code[bit_r];
  wire [31:0] pulse_len = cur_bit ? LONG_CYC : SHORT_CYC; // one = long, zero = short
  wire [31:0] span = pause_r ? PAUSE_CYC : (on_r ? pulse_len : GAP_CYC);
  wire span_done = (cnt_r >= span - 32'h1);
  wire pulse_start = !lamp_r && on_r && !pause_r;
  assign lamp = lamp_r;
  // phases: pulse on, gap off, and after bit 0 a long pause to mark the start
  always_ff @(posedge ref_clk) begin
    if (srst || !run) begin
      cnt_r <= 32'h0;
      bit_r <= 3'h7;
      on_r <= 1'b1;
      pause_r <= 1'b0;
      lamp_r <= 1'b0;
    end else begin
      lamp_r <= on_r && !pause_r;
      cnt_r <= span_done ? 32'h0 : cnt_r + 32'h1;
      if (span_done) begin
        if (pause_r) begin
          pause_r <= 1'b0;
          on_r <= 1'b1;
          bit_r <= 3'h7;
        end else if (on_r) begin
          on_r <= 1'b0;
        end else if (bit_r == 3'h0) begin
          pause_r <= 1'b1;
        end else begin
          on_r <= 1'b1;
          bit_r <= bit_r - 3'h1;
        end
      end
    end
  end
  // checker helpers: length of the current lit stretch, the bit it shows, pulses in this frame
  always_ff @(posedge ref_clk) begin
    if (srst || !run) begin
      lit_len_r <= 32'h0;
      lit_bit_r <= 1'b0;
      pulse_cnt_r <= 4'h0;
    end else begin
      lit_len_r <= lamp_r ? lit_len_r + 32'h1 : 32'h0;
      if (pulse_start) begin
        lit_bit_r <= cur_bit;
      end
      pulse_cnt_r <= pause_r ? 4'h0 : pulse_cnt_r + {3'h0, pulse_start};
    end
  end
  // a lit stretch that has just ended
  sequence pulse_end_s;
    lamp_r ##1 !lamp_r;
  endsequence
  pulse_len_a: assert property (@(posedge ref_clk) disable iff (srst || !run)
    pulse_end_s |-> lit_len_r == (lit_bit_r ? LONG_CYC : SHORT_CYC))
    else $error("pulse length does not match its bit");
  pulse_order_a: assert property (@(posedge ref_clk) disable iff (srst || !run)
    $rose(pause_r) |-> pulse_cnt_r == 4'h8)
    else $error("frame did not carry eight pulses");
  pause_len_a: assert property (@(posedge ref_clk) disable iff (srst || !run)
    $rose(pause_r) |=> !lamp_r [*2])
    else $error("lamp lit during inter-code pause");
endmodule

// ===== rtl/lamp_defines.svh
`ifndef LAMP_DEFINES_SVH
`define LAMP_DEFINES_SVH
// self-test budget and lamp timing in milliseconds, and the clock in hertz
`define SELFTEST_LIMIT_MS 3000
`define CLK_HZ 20000000
`define LONG_PULSE_MS 600
`define SHORT_PULSE_MS 150
`define BIT_GAP_MS 300
`define CODE_PAUSE_MS 2000
`define BLINK_HALF_MS 250
`define MS_CYCLES(ms) ((ms) * (`CLK_HZ / 1000))
// error code ranges, upper nibble
`define CODE_CLASS_SW 4'ha
`define CODE_CLASS_HW 4'hb
`define CODE_CLASS_OP 4'hc
// status byte field positions and reset value
`define STAT_ERR_BIT 0
`define STAT_RESET 8'h00
`endif

// ===== rtl/lamp_pkg.sv
package lamp_pkg;
  typedef enum logic [2:0] {
    ST_TEST = 3'b000,
    ST_BLINK = 3'b001,
    ST_BOOT = 3'b010,
    ST_OFF = 3'b011,
    ST_FAIL = 3'b100
  } phase_e;
  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic steady;
  } fault_s;
  typedef struct packed {
    logic self_test;
    logic transmit;
    logic bus_cycle;
  } lamps_s;
endpackage

// ===== rtl/status_lamp_error_signaler.sv
`timescale 1ns/1ns
`include "lamp_defines.svh"
module status_lamp_error_signaler #(
  parameter int unsigned LIMIT_CYC = `MS_CYCLES(`SELFTEST_LIMIT_MS),
  parameter int unsigned BLINK_CYC = `MS_CYCLES(`BLINK_HALF_MS),
  parameter int unsigned LONG_CYC = `MS_CYCLES(`LONG_PULSE_MS),
  parameter int unsigned SHORT_CYC = `MS_CYCLES(`SHORT_PULSE_MS),
  parameter int unsigned GAP_CYC = `MS_CYCLES(`BIT_GAP_MS),
  parameter int unsigned PAUSE_CYC = `MS_CYCLES(`CODE_PAUSE_MS)
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic bus_init,
  input wire logic host_reset_read,
  input wire logic test_done,
  input wire logic test_pass,
  input wire lamp_pkg::fault_s fault_in,
  input wire logic init_received,
  input wire logic transmitting,
  input wire logic bus_cycle_active,
  input wire logic bus_timeout_option,
  input wire logic network_boot_option,
  output lamp_pkg::lamps_s lamps,
  output logic [7:0] status_byte,
  output logic net_boot_start,
  output logic await_host,
  output logic test_overrun,
  output logic [1:0] code_class
);
  lamp_pkg::phase_e phase_r;
  lamp_pkg::phase_e phase_nxt;
  logic [31:0] tmr_r;
  logic [31:0] blink_cnt_r;
  logic blink_r;
  logic [7:0] code_r;
  logic steady_r;
  logic pass_r;
  logic boot_r;
  logic overrun_r;
  logic flash_lamp;
  logic st_lamp_r;
  logic tx_lamp_r;
  logic bus_lamp_r;
  // any of the three reset sources restarts the whole sequence
  wire restart = srst || bus_init || host_reset_read;
  wire in_test = (phase_r == lamp_pkg::ST_TEST);
  wire in_fail = (phase_r == lamp_pkg::ST_FAIL);
  wire fault_now = fault_in.valid;
  // a configuration fault may arrive from blink, boot or off as well as from test
  wire fault_take = fault_now && (phase_r != lamp_pkg::ST_FAIL);
  wire blink_wrap = (blink_cnt_r >= BLINK_CYC - 32'h1);
  wire [3:0] class_nib = code_r[7:4];
  // phase sequencing; a fault always wins over pass or init in the same cycle
  always_comb begin
    phase_nxt = phase_r;
    unique case (phase_r)
      lamp_pkg::ST_TEST: begin
        if (fault_take) begin
          phase_nxt = lamp_pkg::ST_FAIL;
        end else if (test_done && test_pass) begin
          phase_nxt = network_boot_option ? lamp_pkg::ST_BOOT : lamp_pkg::ST_BLINK;
        end else if (test_done) begin
          phase_nxt = lamp_pkg::ST_FAIL;
        end
      end
      lamp_pkg::ST_BLINK, lamp_pkg::ST_BOOT: begin
        if (fault_take) begin
          phase_nxt = lamp_pkg::ST_FAIL;
        end else if (init_received) begin
          phase_nxt = lamp_pkg::ST_OFF;
        end
      end
      lamp_pkg::ST_OFF: begin
        if (fault_take) begin
          phase_nxt = lamp_pkg::ST_FAIL;
        end
      end
      lamp_pkg::ST_FAIL: begin
        phase_nxt = lamp_pkg::ST_FAIL;
      end
      default: begin
        phase_nxt = lamp_pkg::ST_TEST;
      end
    endcase
  end
  // phase register
  always_ff @(posedge ref_clk) begin
    if (restart) begin
      phase_r <= lamp_pkg::ST_TEST;
    end else begin
      phase_r <= phase_nxt;
    end
  end
  // self-test budget timer; a test that runs past it is flagged and its lamp held steady
  always_ff @(posedge ref_clk) begin
    if (restart) begin
      tmr_r <= 32'h0;
      overrun_r <= 1'b0;
    end else if (in_test) begin
      tmr_r <= tmr_r + 32'h1;
      overrun_r <= overrun_r || (tmr_r >= LIMIT_CYC - 32'h1);
    end
  end
  // latch the fault code and display mode; no code given means steady lamp
  always_ff @(posedge ref_clk) begin
    if (restart) begin
      code_r <= 8'h00;
      steady_r <= 1'b1;
    end else if (fault_take) begin
      code_r <= fault_in.code;
      steady_r <= fault_in.steady;
    end else if (in_test && overrun_r) begin
      steady_r <= 1'b1;
    end
  end
  // even blink: equal on and off halves from one counter
  always_ff @(posedge ref_clk) begin
    if (restart || in_test) begin
      blink_cnt_r <= 32'h0;
      blink_r <= 1'b1;
    end else begin
      blink_cnt_r <= blink_wrap ? 32'h0 : blink_cnt_r + 32'h1;
      if (blink_wrap) begin
        blink_r <= !blink_r;
      end
    end
  end
  // status pass bit stays zero from reset until a clean pass
  always_ff @(posedge ref_clk) begin
    if (restart) begin
      pass_r <= 1'b0;
    end else if (fault_take || in_fail) begin
      pass_r <= 1'b0;
    end else if (in_test && test_done && test_pass) begin
      pass_r <= 1'b1;
    end
  end
  // one-cycle start request for the network download
  always_ff @(posedge ref_clk) begin
    if (restart) begin
      boot_r <= 1'b0;
    end else begin
      boot_r <= in_test && (phase_nxt == lamp_pkg::ST_BOOT);
    end
  end
  code_flasher #(
    .LONG_CYC(LONG_CYC),
    .SHORT_CYC(SHORT_CYC),
    .GAP_CYC(GAP_CYC),
    .PAUSE_CYC(PAUSE_CYC)
  ) i_code_flasher (
    .ref_clk(ref_clk),
    .srst(restart),
    .run(in_fail && !steady_r),
    .code(code_r),
    .lamp(flash_lamp)
  );
  // self-test lamp; every restart source lights it at once, not only the pin reset
  always_ff @(posedge ref_clk) begin
    if (restart) begin
      st_lamp_r <= 1'b1;
    end else begin
      unique case (phase_nxt)
        lamp_pkg::ST_TEST: st_lamp_r <= 1'b1;
        lamp_pkg::ST_BLINK, lamp_pkg::ST_BOOT: st_lamp_r <= blink_r;
        lamp_pkg::ST_OFF: st_lamp_r <= 1'b0;
        lamp_pkg::ST_FAIL: st_lamp_r <= steady_r || flash_lamp;
        default: st_lamp_r <= 1'b1;
      endcase
    end
  end
  // activity lamps follow their inputs; the bus lamp simply follows, so a hung cycle stays lit
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      tx_lamp_r <= 1'b0;
      bus_lamp_r <= 1'b0;
    end else begin
      tx_lamp_r <= transmitting;
      bus_lamp_r <= bus_cycle_active;
    end
  end
  assign lamps.self_test = st_lamp_r;
  assign lamps.transmit = tx_lamp_r;
  assign lamps.bus_cycle = bus_lamp_r;
  assign status_byte = {7'h00, pass_r};
  assign net_boot_start = boot_r;
  assign await_host = (phase_r == lamp_pkg::ST_BLINK);
  assign test_overrun = overrun_r && in_test;
  // class of the latched code: 1 config, 2 hardware, 3 operation, 0 other
  assign code_class = (class_nib == `CODE_CLASS_SW) ? 2'h1 :
                      (class_nib == `CODE_CLASS_HW) ? 2'h2 :
                      (class_nib == `CODE_CLASS_OP) ? 2'h3 : 2'h0;
  // helper age of the test phase, kept apart from the budget timer so the check stands alone
  int unsigned test_age_r;
  always_ff @(posedge ref_clk) begin
    if (restart) begin
      test_age_r <= 0;
    end else if (in_test) begin
      test_age_r <= test_age_r + 1;
    end
  end
  lamp_in_test_a: assert property (@(posedge ref_clk) disable iff (restart)
    in_test && $past(in_test) |=> st_lamp_r)
    else $error("self-test lamp dark during tests");
  lamp_after_init_a: assert property (@(posedge ref_clk) disable iff (restart)
    (phase_r == lamp_pkg::ST_OFF) && !fault_now |=> !st_lamp_r)
    else $error("self-test lamp lit after init");
  test_budget_a: assert property (@(posedge ref_clk) disable iff (restart)
    in_test && (test_age_r >= LIMIT_CYC) |-> test_overrun)
    else $error("self-test overran its budget unchecked");
  pass_bit_a: assert property (@(posedge ref_clk) disable iff (restart)
    status_byte[`STAT_ERR_BIT] |-> !in_test && !in_fail)
    else $error("pass bit set without a clean pass");
  fail_bit_a: assert property (@(posedge ref_clk) disable iff (restart)
    in_fail ##1 in_fail |-> !status_byte[`STAT_ERR_BIT])
    else $error("failure not shown in status");
  tx_lamp_a: assert property (@(posedge ref_clk) disable iff (srst)
    transmitting |=> lamps.transmit)
    else $error("transmit lamp not following transmit");
  bus_lamp_a: assert property (@(posedge ref_clk) disable iff (srst)
    (!bus_timeout_option && bus_cycle_active) [*3] |=> lamps.bus_cycle)
    else $error("bus lamp dark during a hung cycle");
  boot_select_a: assert property (@(posedge ref_clk) disable iff (restart)
    net_boot_start |-> phase_r == lamp_pkg::ST_BOOT && $past(network_boot_option))
    else $error("net boot without option");
  blink_even_a: assert property (@(posedge ref_clk) disable iff (restart)
    (phase_r == lamp_pkg::ST_BLINK) && blink_wrap |=> blink_cnt_r == 32'h0)
    else $error("blink halves uneven");
  // restart and status checks; any restart source re-enters the test phase
  restart_lamp_a: assert property (@(posedge ref_clk)
    restart |=> lamps.self_test)
    else $error("self-test lamp dark after restart");
  status_reset_a: assert property (@(posedge ref_clk)
    restart |=> !status_byte[`STAT_ERR_BIT])
    else $error("pass bit set after restart");
  // a clean pass taken in the test phase
  sequence clean_pass_s;
    in_test && test_done && test_pass && !fault_now ##1 1'b1;
  endsequence
  // a fault taken outside the failure phase
  sequence fault_taken_s;
    fault_take ##1 in_fail;
  endsequence
  pass_sets_a: assert property (@(posedge ref_clk) disable iff (restart)
    clean_pass_s |-> status_byte[`STAT_ERR_BIT])
    else $error("pass bit not set after a clean pass");
  await_pass_a: assert property (@(posedge ref_clk) disable iff (restart)
    clean_pass_s |-> await_host == !$past(network_boot_option))
    else $error("wrong boot choice after pass");
  fault_latch_a: assert property (@(posedge ref_clk) disable iff (restart)
    fault_taken_s |-> (code_r == $past(fault_in.code)) && (steady_r == $past(fault_in.steady)))
    else $error("fault code not latched");
  fault_sticky_a: assert property (@(posedge ref_clk) disable iff (restart)
    in_fail |=> in_fail)
    else $error("failure phase left without restart");
  init_ignored_a: assert property (@(posedge ref_clk) disable iff (restart)
    in_test && init_received && !test_done && !fault_now |=> in_test)
    else $error("init ended the test phase");
  // lamp and side-output checks
  fault_lamp_a: assert property (@(posedge ref_clk) disable iff (restart)
    in_fail && steady_r |=> lamps.self_test)
    else $error("steady fault lamp dark");
  flash_dark_a: assert property (@(posedge ref_clk) disable iff (restart)
    in_fail && !steady_r && !flash_lamp |=> !lamps.self_test)
    else $error("fault lamp lit between pulses");
  blink_follow_a: assert property (@(posedge ref_clk) disable iff (restart)
    (phase_r == lamp_pkg::ST_BLINK || phase_r == lamp_pkg::ST_BOOT) && !init_received && !fault_now
      |=> lamps.self_test == $past(blink_r))
    else $error("self-test lamp not blinking");
  boot_pulse_a: assert property (@(posedge ref_clk) disable iff (restart)
    net_boot_start |=> !net_boot_start)
    else $error("boot start longer than one cycle");
  overrun_early_a: assert property (@(posedge ref_clk) disable iff (restart)
    test_overrun |-> test_age_r >= LIMIT_CYC)
    else $error("overrun flagged before budget");
  class_other_a: assert property (@(posedge ref_clk) disable iff (restart)
    code_class == 2'h0 |-> (class_nib < `CODE_CLASS_SW) || (class_nib > `CODE_CLASS_OP))
    else $error("code in a class range not classed");
  tx_idle_a: assert property (@(posedge ref_clk) disable iff (srst)
    !transmitting |=> !lamps.transmit)
    else $error("transmit lamp lit while idle");
  bus_idle_a: assert property (@(posedge ref_clk) disable iff (srst)
    !bus_cycle_active |=> !lamps.bus_cycle)
    else $error("bus lamp lit with no cycle");
endmodule

// ===== verification/lamp_observer.sv
`timescale 1ns/1ns
// reads the self-test lamp the way a person would: long on is 1, short on is 0
module lamp_observer #(
  parameter int unsigned SPLIT = 5,
  parameter int unsigned QUIET = 12
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic lamp,
  output logic [7:0] seen_code,
  output logic [7:0] codes_seen
);
  int unsigned on_len;
  int unsigned off_len;
  logic [3:0] bits_r;
  logic [7:0] shift_r;
  // a stretch longer than any gap marks the start of a repetition; a
  // partial frame (such as the steady test lamp) is discarded there
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      on_len <= 0;
      off_len <= 0;
      bits_r <= 4'h0;
      codes_seen <= 8'h00;
      seen_code <= 8'h00;
    end else if (lamp) begin
      on_len <= on_len + 1;
      off_len <= 0;
    end else begin
      if (on_len != 0) begin
        shift_r <= {shift_r[6:0], on_len > SPLIT};
        bits_r <= bits_r + 4'h1;
      end
      on_len <= 0;
      off_len <= off_len + 1;
      if (off_len == QUIET) begin
        if (bits_r == 4'h8) begin
          seen_code <= shift_r;
          codes_seen <= codes_seen + 8'h01;
        end
        bits_r <= 4'h0;
      end
    end
  end
endmodule

// ===== verification/status_lamp_error_signaler_bench.sv
`timescale 1ns/1ns
module status_lamp_error_signaler_bench;
  localparam int LIMIT = 200;
  logic ref_clk, srst, bus_init, host_reset_read, test_done, test_pass, init_received;
  logic transmitting, bus_cycle_active, bus_timeout_option, network_boot_option;
  lamp_pkg::fault_s fault;
  lamp_pkg::lamps_s lamps;
  logic [7:0] status_byte, seen_code, codes_seen;
  logic net_boot_start, await_host, test_overrun;
  logic [1:0] code_class;
  int fail_count = 0;
  int total_checks = 0;
  int boot_pulses = 0;

  status_lamp_error_signaler #(.LIMIT_CYC(LIMIT), .BLINK_CYC(4), .LONG_CYC(8), .SHORT_CYC(3), .GAP_CYC(4),
    .PAUSE_CYC(20)) i_status_lamp_error_signaler (.ref_clk(ref_clk), .srst(srst), .bus_init(bus_init),
    .host_reset_read(host_reset_read), .test_done(test_done), .test_pass(test_pass), .fault_in(fault),
    .init_received(init_received), .transmitting(transmitting), .bus_cycle_active(bus_cycle_active),
    .bus_timeout_option(bus_timeout_option), .network_boot_option(network_boot_option), .lamps(lamps),
    .status_byte(status_byte), .net_boot_start(net_boot_start), .await_host(await_host),
    .test_overrun(test_overrun), .code_class(code_class));
  lamp_observer i_lamp_observer (.ref_clk(ref_clk), .srst(srst), .lamp(lamps.self_test),
    .seen_code(seen_code), .codes_seen(codes_seen));

  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // boot start is a one-cycle pulse, so it is counted at every edge
  always @(posedge ref_clk) if (net_boot_start === 1'b1) boot_pulses++;

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // counts cycles with the chosen lamp lit: 0 self-test, 1 transmit, 2 bus
  task automatic lit(input int n, input int sel, output logic [7:0] ons);
    ons = 8'h00;
    repeat (n) begin
      @(negedge ref_clk);
      ons = ons + {7'h00, sel == 0 ? lamps.self_test : sel == 1 ? lamps.transmit : lamps.bus_cycle};
    end
  endtask
  task automatic restart(input int kind);
    @(negedge ref_clk);
    if (kind == 0) srst = 1'b1;
    else if (kind == 1) bus_init = 1'b1;
    else host_reset_read = 1'b1;
    tick(1);
    {srst, bus_init, host_reset_read} = 3'b000;
    tick(1);
    chk("test lamp", 8'h01, {7'h00, lamps.self_test});
    chk("status", 8'h00, status_byte);
  endtask
  task automatic finish_test(input logic pass);
    @(negedge ref_clk);
    {test_done, test_pass} = {1'b1, pass};
    tick(1);
    test_done = 1'b0;
    tick(2);
  endtask

  task automatic t_blink();
    logic [7:0] ons;
    restart(0);
    init_received = 1'b1;
    tick(1);
    init_received = 1'b0;
    lit(10, 0, ons);
    chk("init during test", 8'h0a, ons);
    finish_test(1'b1);
    chk("status pass", 8'h01, status_byte);
    chk("await host", 8'h01, {7'h00, await_host});
    lit(32, 0, ons);
    chk("blink on count", 8'h10, ons);
    init_received = 1'b1;
    tick(1);
    init_received = 1'b0;
    tick(2);
    lit(20, 0, ons);
    chk("lamp after init", 8'h00, ons);
  endtask
  task automatic t_boot();
    network_boot_option = 1'b1;
    restart(1);
    boot_pulses = 0;
    finish_test(1'b1);
    tick(4);
    chk("boot pulses", 8'h01, boot_pulses[7:0]);
    chk("await host boot", 8'h00, {7'h00, await_host});
    network_boot_option = 1'b0;
  endtask
  task automatic t_fail();
    logic [7:0] ons;
    restart(2);
    finish_test(1'b0);
    lit(30, 0, ons);
    chk("fail steady", 8'h1e, ons);
    chk("status fail", 8'h00, status_byte);
    restart(0);
    tick(LIMIT + 10);
    chk("overrun", 8'h01, {7'h00, test_overrun});
    chk("overrun status", 8'h00, status_byte);
  endtask
  task automatic t_codes();
    logic [7:0] codes [3] = '{8'ha7, 8'hb5, 8'hc9};
    logic [7:0] base;
    int w;
    for (int i = 0; i < 3; i++) begin
      restart(0);
      if (i == 0) finish_test(1'b1);
      fault.valid = 1'b1;
      fault.code = codes[i];
      fault.steady = 1'b0;
      tick(1);
      fault.valid = 1'b0;
      tick(1);
      chk("class", 8'(i + 1), {6'h00, code_class});
      chk("status fault", 8'h00, status_byte);
      base = codes_seen;
      w = 0;
      while (codes_seen !== base + 8'h02 && w < 600) begin
        tick(1);
        w++;
      end
      chk("code repeats", base + 8'h02, codes_seen);
      chk("flashed code", codes[i], seen_code);
    end
  endtask
  task automatic t_side();
    logic [7:0] ons;
    transmitting = 1'b1;
    tick(2);
    chk("tx lamp on", 8'h01, {7'h00, lamps.transmit});
    transmitting = 1'b0;
    lit(10, 1, ons);
    chk("tx lamp idle", 8'h00, ons);
    bus_cycle_active = 1'b1;
    tick(1);
    lit(30, 2, ons);
    chk("bus lamp hung", 8'h1e, ons);
    bus_cycle_active = 1'b0;
    lit(10, 2, ons);
    chk("bus lamp idle", 8'h00, ons);
  endtask

  // watchdog sized well above the one to two thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    close_out();
  end
  initial begin
    {srst, bus_init, host_reset_read, test_done, test_pass, init_received} = 6'b100000;
    {transmitting, bus_cycle_active, bus_timeout_option, network_boot_option} = 4'h0;
    fault = '0;
    tick(20);
    srst = 1'b0;
    t_blink();
    t_boot();
    t_fail();
    t_codes();
    t_side();
    close_out();
  end
endmodule
